// [logic/lvi_ctl.sv]
/*
 * low-voltage detect interrupt controller: enables, fall/rise flags,
 * detection signal, interrupt line 0 request and reset hand-off.
 * assumes analog comparators driving asynchronous levels and an
 * AXI4-Lite master on aclk; aresetn stands for the power-on reset.
 */
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lvi_consts.svh"

module lvi_ctl
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    input  wire lvi_pkg::lvi_axi_req_s axi_req,
    output lvi_pkg::lvi_axi_rsp_s      axi_rsp,
    input  wire logic                 cmp_below_lower,
    input  wire logic                 cmp_above_upper,
    input  wire logic                 cmp_below_reset,
    output logic                      detect_int_n,
    output logic                      ext_irq_line0,
    output logic                      lowv_reset_req
);
    import lvi_pkg::*;

    localparam int SETTLE_CYC = `LVI_SETTLE_CYC;

    logic [2:0]   cmp_lvl;
    lvi_axi_rsp_s rsp_ff, nxt_rsp;
    logic [7:0]   waddr_ff, nxt_waddr;
    logic         wbad_ff, nxt_wbad;
    logic [31:0]  wdata_ff, nxt_wdata;
    logic         wlane_ff, nxt_wlane;
    lvi_ctl_s     ctl_ff, nxt_ctl;
    logic         fall_flag_ff, nxt_fall_flag;
    logic         rise_flag_ff, nxt_rise_flag;
    logic         fall_arm_ff, nxt_fall_arm;
    logic         rise_arm_ff, nxt_rise_arm;
    lvi_det_e     state_ff, nxt_state;
    logic         int_n_ff, nxt_int_n;
    logic         irq_ff, nxt_irq;
    logic         rreq_ff, nxt_rreq;
    logic [9:0]   settle_ff, nxt_settle;
    logic         do_write, do_read, stat_wr, settled;
    logic         below_lo, above_up, below_rst;
    logic [31:0]  rd_word;

    lvi_sync #(.W(3)) u_sync
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .async_in ({cmp_below_reset, cmp_above_upper, cmp_below_lower}),
        .level    (cmp_lvl)
    );

    assign below_lo  = cmp_lvl[0];
    assign above_up  = cmp_lvl[1];
    assign below_rst = cmp_lvl[2];
    assign settled   = (settle_ff == 10'(SETTLE_CYC));

    // both write channels held and no response pending
    assign do_write = !rsp_ff.awready && !rsp_ff.wready && !rsp_ff.bvalid;
    assign do_read  = axi_req.arvalid && rsp_ff.arready;
    assign stat_wr  = do_write && !wbad_ff && wlane_ff &&
                      waddr_ff == `LVI_STAT_OFS;

    always_comb
    begin
        rd_word = 32'h0;
        case (axi_req.araddr[7:0])
            `LVI_CTRL_OFS:  rd_word[3:0] = ctl_ff;
            `LVI_STAT_OFS:  rd_word[7:0] = `LVI_STAT_RSVD |
                {6'h0, fall_flag_ff, rise_flag_ff};
            `LVI_STATE_OFS: rd_word[5:0] = {cmp_lvl, rreq_ff, settled,
                int_n_ff};
            default:        rd_word = 32'h0;
        endcase
    end

    // register bus
    always_comb
    begin
        nxt_rsp   = rsp_ff;
        nxt_waddr = waddr_ff;
        nxt_wbad  = wbad_ff;
        nxt_wdata = wdata_ff;
        nxt_wlane = wlane_ff;
        if (axi_req.awvalid && rsp_ff.awready)
        begin
            nxt_rsp.awready = 1'b0;
            nxt_waddr = axi_req.awaddr[7:0];
            nxt_wbad  = (axi_req.awaddr[31:8] != 24'h0) ||
                        (axi_req.awaddr[7:0] != `LVI_CTRL_OFS &&
                         axi_req.awaddr[7:0] != `LVI_STAT_OFS &&
                         axi_req.awaddr[7:0] != `LVI_STATE_OFS);
        end
        if (axi_req.wvalid && rsp_ff.wready)
        begin
            nxt_rsp.wready = 1'b0;
            nxt_wdata = axi_req.wdata;
            nxt_wlane = axi_req.wstrb[0];
        end
        if (do_write)
        begin
            nxt_rsp.bvalid = 1'b1;
            nxt_rsp.bresp  = wbad_ff ? `LVI_RESP_SLVERR : `LVI_RESP_OKAY;
        end
        if (rsp_ff.bvalid && axi_req.bready)
        begin
            nxt_rsp.bvalid  = 1'b0;
            nxt_rsp.awready = 1'b1;
            nxt_rsp.wready  = 1'b1;
        end
        if (do_read)
        begin
            nxt_rsp.arready = 1'b0;
            nxt_rsp.rvalid  = 1'b1;
            nxt_rsp.rdata   = rd_word;
            nxt_rsp.rresp   = (axi_req.araddr[31:8] != 24'h0 ||
                (axi_req.araddr[7:0] != `LVI_CTRL_OFS &&
                 axi_req.araddr[7:0] != `LVI_STAT_OFS &&
                 axi_req.araddr[7:0] != `LVI_STATE_OFS)) ?
                `LVI_RESP_SLVERR : `LVI_RESP_OKAY;
            if (nxt_rsp.rresp == `LVI_RESP_SLVERR)
                nxt_rsp.rdata = 32'h0;
        end
        if (rsp_ff.rvalid && axi_req.rready)
        begin
            nxt_rsp.rvalid  = 1'b0;
            nxt_rsp.arready = 1'b1;
        end
    end

    // control, flags and detector
    always_comb
    begin
        nxt_ctl       = ctl_ff;
        nxt_fall_flag = fall_flag_ff;
        nxt_rise_flag = rise_flag_ff;
        nxt_fall_arm  = fall_arm_ff;
        nxt_rise_arm  = rise_arm_ff;
        nxt_state     = state_ff;
        nxt_int_n     = int_n_ff;
        nxt_irq       = 1'b0;
        nxt_rreq      = rreq_ff;
        nxt_settle    = settle_ff;
        // software owns the enable order; the block takes each write with byte lane 0 enabled as is
        if (do_write && !wbad_ff && wlane_ff &&
            waddr_ff == `LVI_CTRL_OFS)
            nxt_ctl = wdata_ff[3:0];
        if (!ctl_ff.master)
            nxt_settle = 10'h0;
        else if (!settled)
            nxt_settle = settle_ff + 10'h1;
        // arming on a read that returns the flag set
        if (do_read && axi_req.araddr == 32'(`LVI_STAT_OFS))
        begin
            nxt_fall_arm = fall_arm_ff || fall_flag_ff;
            nxt_rise_arm = rise_arm_ff || rise_flag_ff;
        end
        if (stat_wr)
        begin
            if (!wdata_ff[`LVI_FALL_BIT] && fall_arm_ff)
                nxt_fall_flag = 1'b0;
            if (!wdata_ff[`LVI_RISE_BIT] && rise_arm_ff)
                nxt_rise_flag = 1'b0;
            nxt_fall_arm = 1'b0;
            nxt_rise_arm = 1'b0;
        end
        case (state_ff)
            ST_STANDBY:
            begin
                nxt_int_n = 1'b1;
                if (ctl_ff.master)
                    nxt_state = ST_NORMAL;
            end
            ST_NORMAL:
            begin
                if (below_lo)
                begin
                    nxt_state     = ST_LOW;
                    nxt_int_n     = 1'b0;
                    nxt_fall_flag = 1'b1;
                    nxt_irq       = ctl_ff.fall_en;
                end
            end
            ST_LOW:
            begin
                if (below_rst)
                begin
                    nxt_state = ST_RESET;
                    nxt_rreq  = ctl_ff.reset_en;
                end
                else if (above_up)
                begin
                    nxt_state = ST_NORMAL;
                    nxt_int_n = 1'b1;
                    if (ctl_ff.rise_en)
                    begin
                        nxt_rise_flag = 1'b1;
                        nxt_irq       = 1'b1;
                    end
                end
            end
            ST_RESET:
            begin
                // with the reset function off, recovery is silent
                if (!ctl_ff.reset_en && !below_rst && above_up)
                begin
                    nxt_state = ST_NORMAL;
                    nxt_int_n = 1'b1;
                end
            end
            default: nxt_state = ST_STANDBY;
        endcase
        if (!ctl_ff.master)
        begin
            nxt_state = ST_STANDBY;
            nxt_int_n = 1'b1;
            nxt_irq   = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rsp_ff       <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                              default: '0};
            waddr_ff     <= 8'h0;
            wbad_ff      <= 1'b0;
            wdata_ff     <= 32'h0;
            wlane_ff     <= 1'b0;
            ctl_ff       <= `LVI_CTRL_RST;
            fall_flag_ff <= 1'b0;
            rise_flag_ff <= 1'b0;
            fall_arm_ff  <= 1'b0;
            rise_arm_ff  <= 1'b0;
            state_ff     <= ST_STANDBY;
            int_n_ff     <= 1'b1;
            irq_ff       <= 1'b0;
            rreq_ff      <= 1'b0;
            settle_ff    <= 10'h0;
        end
        else if (ce)
        begin
            rsp_ff       <= nxt_rsp;
            waddr_ff     <= nxt_waddr;
            wbad_ff      <= nxt_wbad;
            wdata_ff     <= nxt_wdata;
            wlane_ff     <= nxt_wlane;
            ctl_ff       <= nxt_ctl;
            fall_flag_ff <= nxt_fall_flag;
            rise_flag_ff <= nxt_rise_flag;
            fall_arm_ff  <= nxt_fall_arm;
            rise_arm_ff  <= nxt_rise_arm;
            state_ff     <= nxt_state;
            int_n_ff     <= nxt_int_n;
            irq_ff       <= nxt_irq;
            rreq_ff      <= nxt_rreq;
            settle_ff    <= nxt_settle;
        end
    end

    assign axi_rsp        = rsp_ff;
    assign detect_int_n   = int_n_ff;
    assign ext_irq_line0  = irq_ff;
    assign lowv_reset_req = rreq_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_standby;
        (ce && !ctl_ff.master) |=> (state_ff == ST_STANDBY && !irq_ff &&
            int_n_ff);
    endproperty
    a_standby: assert property (p_standby)
        else $error("detector active while master enable low");

    property p_fall;
        (ce && ctl_ff.master && state_ff == ST_NORMAL && below_lo) |=>
            (!int_n_ff && fall_flag_ff);
    endproperty
    a_fall: assert property (p_fall)
        else $error("fall did not drop detect and set flag");

    property p_fall_irq;
        (ce && ctl_ff.master && state_ff == ST_NORMAL && below_lo) |=>
            (irq_ff == $past(ctl_ff.fall_en) && fall_flag_ff &&
             !int_n_ff);
    endproperty
    a_fall_irq: assert property (p_fall_irq)
        else $error("fall request not tied to fall enable");

    property p_rise;
        (ce && ctl_ff.master && state_ff == ST_LOW && !below_rst &&
         above_up) |=> (int_n_ff && state_ff == ST_NORMAL);
    endproperty
    a_rise: assert property (p_rise)
        else $error("rise did not release detect");

    property p_rise_irq;
        (ce && ctl_ff.master && state_ff == ST_LOW && !below_rst &&
         above_up && !rise_flag_ff) |=>
            (irq_ff == $past(ctl_ff.rise_en) &&
             rise_flag_ff == $past(ctl_ff.rise_en));
    endproperty
    a_rise_irq: assert property (p_rise_irq)
        else $error("rise flag and request not tied to rise enable");

    property p_reset_handoff;
        (ce && ctl_ff.master && ctl_ff.reset_en && state_ff == ST_LOW &&
         below_rst) |=> (lowv_reset_req && !irq_ff) ##1 lowv_reset_req;
    endproperty
    a_reset_handoff: assert property (p_reset_handoff)
        else $error("reset hand-off missing");

    property p_flag_hold;
        (ce && stat_wr && fall_flag_ff && !fall_arm_ff) |=> fall_flag_ff;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("fall flag cleared without prior read");

    property p_flag_clear;
        (ce && stat_wr && rise_flag_ff && rise_arm_ff &&
         !wdata_ff[`LVI_RISE_BIT] && state_ff != ST_LOW) |=> !rise_flag_ff;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("armed rise flag not cleared by zero write");

    c_fall_irq:  cover property (ce && ctl_ff.fall_en ##1 irq_ff);
    c_rise_flag: cover property ($rose(rise_flag_ff));
    c_handoff:   cover property ($rose(lowv_reset_req));
    c_clear:     cover property ($fell(fall_flag_ff));

endmodule // lvi_ctl

// [common/lvi_consts.svh]
/*
 * register offsets, field positions, reset values and timing counts of the
 * low-voltage detect interrupt controller.
 * assumes a 10 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
`ifndef LVI_CONSTS_SVH
`define LVI_CONSTS_SVH

`define LVI_CTRL_OFS     8'h00
`define LVI_STAT_OFS     8'h04
`define LVI_STATE_OFS    8'h08

`define LVI_CTRL_RST     4'h0
`define LVI_STAT_RSVD    8'hfc
`define LVI_FALL_BIT     1
`define LVI_RISE_BIT     0

`define LVI_ST_INTN_BIT  0
`define LVI_ST_SETL_BIT  1
`define LVI_ST_RREQ_BIT  2
`define LVI_ST_CMP_LSB   3

`define LVI_RESP_OKAY    2'b00
`define LVI_RESP_SLVERR  2'b10

`define LVI_SETTLE_NS    50000
`define LVI_CLK_NS       100
`define LVI_SETTLE_CYC   ((`LVI_SETTLE_NS + `LVI_CLK_NS - 1) / `LVI_CLK_NS)

`endif

// [common/lvi_pkg.sv]
/*
 * types shared by the low-voltage detect interrupt controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package lvi_pkg;

    typedef enum logic [1:0]
    {
        ST_STANDBY = 2'b00,
        ST_NORMAL  = 2'b01,
        ST_LOW     = 2'b10,
        ST_RESET   = 2'b11
    } lvi_det_e;

    typedef struct packed
    {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } lvi_axi_req_s;

    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } lvi_axi_rsp_s;

    // control word, master enable in bit 0
    typedef struct packed
    {
        logic rise_en;
        logic fall_en;
        logic reset_en;
        logic master;
    } lvi_ctl_s;

endpackage

// [logic/lvi_sync.sv]
/*
 * three-stage synchroniser for the comparator levels.
 * assumes asynchronous, slowly changing inputs; a level is taken over
 * once the second and third stages agree.
 */
`timescale 1ns/1ps
module lvi_sync
#(
    parameter int W = 3
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] level_ff;
    logic [W-1:0] nxt_level;

    always_comb
    begin
        // s1 feeds only s2, never the filter
        nxt_level = level_ff;
        for (int i = 0; i < W; i++)
        begin
            if (s2_ff[i] == s3_ff[i])
                nxt_level[i] = s3_ff[i];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            level_ff <= '0;
        end
        else if (ce)
        begin
            s1_ff    <= async_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;

    property p_sync_agree;
        @(posedge aclk) disable iff (!aresetn)
        (level_ff != $past(level_ff)) |-> ($past(ce) && $past(s2_ff) ==
            $past(s3_ff) && $past(s3_ff) == level_ff);
    endproperty
    a_sync_agree: assert property (p_sync_agree)
        else $error("level changed before stages agreed");

endmodule // lvi_sync

// [bench/low_voltage_detect_interrupt_ctl_tb.sv]
/*
 * self-checking bench for the low-voltage detect interrupt controller.
 * assumes lvi_ctl with its AXI4-Lite slave on aclk; the comparators are
 * driven as clean levels.
 */
`timescale 1ns/1ps
`include "lvi_consts.svh"
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end

module low_voltage_detect_interrupt_ctl_tb;
    import lvi_pkg::*;

    logic         aclk;
    logic         aresetn;
    logic         ce;
    lvi_axi_req_s axi_req;
    lvi_axi_rsp_s axi_rsp;
    logic         cmp_below_lower;
    logic         cmp_above_upper;
    logic         cmp_below_reset;
    logic         detect_int_n;
    logic         ext_irq_line0;
    logic         lowv_reset_req;
    int           mismatches;
    int           comparisons;
    int           k;
    logic [31:0]  seed;
    logic [31:0]  rd;
    logic [1:0]   resp;
    logic [3:0]   ctrl_exp;
    logic [3:0]   strb;

    lvi_ctl i_dut
    (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .ce              (ce),
        .axi_req         (axi_req),
        .axi_rsp         (axi_rsp),
        .cmp_below_lower (cmp_below_lower),
        .cmp_above_upper (cmp_above_upper),
        .cmp_below_reset (cmp_below_reset),
        .detect_int_n    (detect_int_n),
        .ext_irq_line0   (ext_irq_line0),
        .lowv_reset_req  (lowv_reset_req)
    );

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // status word: bits 7:2 always read as ones
    function automatic logic [31:0] exp_stat(input logic f, input logic r);
        return {24'h0, 6'h3f, f, r};
    endfunction

    task automatic complete_run;
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic axi_write(input logic [31:0] addr, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] code);
        int i;
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= addr;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= s;
        axi_req.bready  <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (axi_req.awvalid && axi_rsp.awready)
                axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready)
                axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid)
            begin
                code = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
                break;
            end
        end
        if (i == 100)
        begin
            mismatches++;
            complete_run();
        end
    endtask

    task automatic axi_read(input logic [31:0] addr, output logic [31:0] d,
                            output logic [1:0] code);
        int i;
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= addr;
        axi_req.rready  <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (axi_req.arvalid && axi_rsp.arready)
                axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid)
            begin
                d = axi_rsp.rdata;
                code = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
                break;
            end
        end
        if (i == 100)
        begin
            mismatches++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        axi_write({24'h0, ofs}, d, 4'hf, resp);
        `CHK("write resp", `LVI_RESP_OKAY, resp)
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
        axi_read({24'h0, ofs}, rd, resp);
        `CHK("read data", exp, rd)
        `CHK("read resp", `LVI_RESP_OKAY, resp)
    endtask

    task automatic supply(input logic lo, input logic hi, input logic rs);
        @(posedge aclk);
        cmp_below_lower <= lo;
        cmp_above_upper <= hi;
        cmp_below_reset <= rs;
    endtask

    // the request pulse must coincide with the edge that moves detect
    task automatic wait_detect(input logic lvl, input logic irq_exp);
        int n;
        for (n = 1; n <= 30; n++)
        begin
            @(posedge aclk);
            #1;
            if (detect_int_n === lvl)
                break;
        end
        `CHK("detect level", lvl, detect_int_n)
        `CHK("line0 request", irq_exp, ext_irq_line0)
        `CHK("sync delay", 32'd5, n)
    endtask

    initial
    begin
        mismatches = 0;
        comparisons = 0;
        seed = 32'h1df2;
        ce = 1'b1;
        aresetn = 1'b0;
        axi_req = '0;
        cmp_below_lower = 1'b0;
        cmp_above_upper = 1'b1;
        cmp_below_reset = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`LVI_CTRL_OFS, 32'h0);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b0, 1'b0));
        axi_read(32'h0000_0100, rd, resp);
        `CHK("unmapped read", `LVI_RESP_SLVERR, resp)
        `CHK("unmapped data", 32'h0, rd)
        axi_write(32'h0000_000c, 32'hf, 4'hf, resp);
        `CHK("unmapped write", `LVI_RESP_SLVERR, resp)
        // supply dips while still in standby: nothing may react
        supply(1'b1, 1'b0, 1'b0);
        repeat (12)
        begin
            @(posedge aclk);
            #1;
            `CHK("standby detect", 1'b1, detect_int_n)
            `CHK("standby line0", 1'b0, ext_irq_line0)
        end
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b0, 1'b0));
        supply(1'b0, 1'b1, 1'b0);
        repeat (8) @(posedge aclk);
        ctrl_exp = 4'h0;
        for (k = 0; k < 6; k++)
        begin
            seed = lfsr(seed);
            strb = {seed[7:5], seed[8] & (k != 0)};
            axi_write({24'h0, `LVI_CTRL_OFS}, seed, strb, resp);
            `CHK("ctrl write resp", `LVI_RESP_OKAY, resp)
            if (strb[0])
                ctrl_exp = seed[3:0];
            rd_chk(`LVI_CTRL_OFS, {28'h0, ctrl_exp});
        end
        wr(`LVI_CTRL_OFS, 32'h0);
        wr(`LVI_CTRL_OFS, 32'h1);
        // idle supply: only above_upper is set, settling not yet done
        rd_chk(`LVI_STATE_OFS, 32'h11);
        repeat (`LVI_SETTLE_CYC) @(posedge aclk);
        rd_chk(`LVI_STATE_OFS, 32'h13);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b0, 1'b0));
        wr(`LVI_STAT_OFS, 32'h0);
        wr(`LVI_CTRL_OFS, 32'hd);
        // port output set-up may only start from here on
        supply(1'b1, 1'b0, 1'b0);
        wait_detect(1'b0, 1'b1);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b1, 1'b0));
        supply(1'b0, 1'b1, 1'b0);
        wait_detect(1'b1, 1'b1);
        // fall was read as set and clears; rise was never read, stays
        wr(`LVI_STAT_OFS, 32'h0);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b0, 1'b1));
        wr(`LVI_STAT_OFS, 32'h0);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b0, 1'b0));
        wr(`LVI_STAT_OFS, 32'h3);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b0, 1'b0));
        wr(`LVI_CTRL_OFS, 32'h5);
        // clock enable low holds off the whole detection path
        supply(1'b1, 1'b0, 1'b0);
        ce <= 1'b0;
        repeat (10)
        begin
            @(posedge aclk);
            #1;
            `CHK("frozen detect", 1'b1, detect_int_n)
        end
        @(posedge aclk);
        ce <= 1'b1;
        wait_detect(1'b0, 1'b1);
        supply(1'b0, 1'b1, 1'b0);
        wait_detect(1'b1, 1'b0);
        rd_chk(`LVI_STAT_OFS, exp_stat(1'b1, 1'b0));
        wr(`LVI_STAT_OFS, 32'h0);
        wr(`LVI_CTRL_OFS, 32'h3);
        supply(1'b1, 1'b0, 1'b0);
        wait_detect(1'b0, 1'b0);
        supply(1'b1, 1'b0, 1'b1);
        for (k = 0; k < 30 && lowv_reset_req !== 1'b1; k++)
            @(posedge aclk);
        `CHK("reset hand-off", 1'b1, lowv_reset_req)
        rd_chk(`LVI_STATE_OFS, 32'h2e);
        // master alone stays on first, then a later write clears master too
        wr(`LVI_CTRL_OFS, 32'h1);
        wr(`LVI_CTRL_OFS, 32'h0);
        repeat (3) @(posedge aclk);
        #1;
        `CHK("standby detect", 1'b1, detect_int_n)
        `CHK("hand-off held", 1'b1, lowv_reset_req)
        supply(1'b0, 1'b1, 1'b0);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHK("hand-off cleared", 1'b0, lowv_reset_req)
        rd_chk(`LVI_CTRL_OFS, 32'h0);
        complete_run();
    end
endmodule // low_voltage_detect_interrupt_ctl_tb
